// ===== design/jtag_tap_regs.svh
// constants for the four-wire test access port
`ifndef JTAG_TAP_REGS_SVH
`define JTAG_TAP_REGS_SVH
`define TAP_IR_W 3
`define TAP_DBG_W 10
`define TAP_PROG_W 3
`define TAP_IR_EXTEST 3'h0
`define TAP_IR_SAMPLE 3'h1
`define TAP_IR_DEBUG 3'h2
`define TAP_IR_BYPASS 3'h3
`define TAP_IR_PROG 3'h4
`define TAP_IR_RSVD 3'h6
`define TAP_IR_CAPTURE 3'h1
`define TAP_FIFO_DEPTH 8
`define TAP_TCK_MIN_DIV 8
`define TAP_RESET_TMS_EDGES 3'h5
`define TAP_EN_RESET 1'h1
`endif

// ===== design/jtag_tap_pkg.sv
// types for the four-wire test access port
package jtag_tap_pkg;
   typedef enum logic [3:0] {
      ST_EXIT2_DR = 4'h0, ST_EXIT1_DR = 4'h1, ST_SHIFT_DR = 4'h2, ST_PAUSE_DR = 4'h3,
      ST_SEL_IR = 4'h4, ST_UPDATE_DR = 4'h5, ST_CAPTURE_DR = 4'h6, ST_SEL_DR = 4'h7,
      ST_EXIT2_IR = 4'h8, ST_EXIT1_IR = 4'h9, ST_SHIFT_IR = 4'ha, ST_PAUSE_IR = 4'hb,
      ST_IDLE = 4'hc, ST_UPDATE_IR = 4'hd, ST_CAPTURE_IR = 4'he, ST_RESET = 4'hf
   } tap_state_e;
   typedef enum logic [1:0] {
      PATH_BYPASS = 2'h0,
      PATH_DEBUG = 2'h1,
      PATH_PROG = 2'h2
   } dr_path_e;
endpackage : jtag_tap_pkg

// ===== design/jtag_tap_controller.sv
// test access port controller with response fifo
//
// Function
// - tdo changes on falling tck only, only in shift states, lsb first
// - host sends tdi lsb first; sampled on rising tck
// - with tck stopped low and the port enabled, state, instruction and shift registers hold outside test-logic-reset; the response fifo still fills
// - tms sampled on each rising tck chooses the next state
// - port serves pins after reset; enable bit 0 frees the pins
// - reset enters test-logic-reset with bypass code in instruction latch
// - five high tms samples reach test-logic-reset from any state
// - stays in test-logic-reset while tms sampled high
// - one low tms goes to idle; three highs return to reset
// - capture-ir loads 001 into the instruction shift register
// - shift-ir shifts 3-bit register toward tdo taking tdi in
// - update-ir loads instruction latch on falling tck; test-logic-reset and disable load the bypass code; else it holds
// - new instruction is decoded to choose the data path and length
// - 011/101/111 bypass, 010 debug 10 bits, 100 program 3 bits
// - codes 000 and 001 leave the data path selection unchanged
// - bypass puts one bit between tdi and tdo in shift-dr
// - update-dr latches shifted data to the debug or program buffer and reloads the shift register; debug reloads from the fifo only when it holds a word
`timescale 1ns/1ns
`include "jtag_tap_regs.svh"

module tap_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic push, pop;

   assign in_ready_o = (wr_q - rd_q) != (AW + 1)'(DEPTH);
   assign out_valid_o = wr_q != rd_q;
   assign out_data_o = mem_q[rd_q[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end
endmodule : tap_fifo

module jtag_tap_controller (
   // system clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // port enable bit of the system control register
   input wire logic tap_en_i,
   output logic pins_tap_o,
   // test pins
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   // controller view
   output jtag_tap_pkg::tap_state_e tap_state_o,
   output logic [`TAP_IR_W-1:0] instruction_latch_o,
   output jtag_tap_pkg::dr_path_e dr_path_o,
   // debug words to the debug engine
   output logic dbg_cmd_valid_o,
   output logic [`TAP_DBG_W-1:0] dbg_cmd_o,
   // debug answers from the debug engine
   input wire logic rsp_valid_i,
   output logic rsp_ready_o,
   input wire logic [`TAP_DBG_W-1:0] rsp_data_i,
   // programming word
   output logic [`TAP_PROG_W-1:0] prog_data_o
);
   // pin synchronisers
   logic tck_s1_q, tck_s2_q, tck_s3_q, tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q;
   logic tck_rise, tck_fall;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         tck_s1_q <= 1'h1;
         tck_s2_q <= 1'h1;
         tck_s3_q <= 1'h1;
         tms_s1_q <= 1'h1;
         tms_s2_q <= 1'h1;
         tdi_s1_q <= 1'h1;
         tdi_s2_q <= 1'h1;
      end else begin
         tck_s1_q <= tck_i;
         tck_s2_q <= tck_s1_q;
         tck_s3_q <= tck_s2_q;
         tms_s1_q <= tms_i;
         tms_s2_q <= tms_s1_q;
         tdi_s1_q <= tdi_i;
         tdi_s2_q <= tdi_s1_q;
      end
   end

   // tms and tdi sampled on rising tck, tdo driven on falling tck
   assign tck_rise = tck_s2_q && !tck_s3_q;
   assign tck_fall = !tck_s2_q && tck_s3_q;

   function automatic jtag_tap_pkg::tap_state_e next_state(
      input jtag_tap_pkg::tap_state_e s,
      input logic tms
   );
      jtag_tap_pkg::tap_state_e n;
      n = s;
      unique case (s)
         jtag_tap_pkg::ST_RESET: n = tms ? jtag_tap_pkg::ST_RESET : jtag_tap_pkg::ST_IDLE;
         jtag_tap_pkg::ST_IDLE: n = tms ? jtag_tap_pkg::ST_SEL_DR : jtag_tap_pkg::ST_IDLE;
         jtag_tap_pkg::ST_SEL_DR: n = tms ? jtag_tap_pkg::ST_SEL_IR : jtag_tap_pkg::ST_CAPTURE_DR;
         jtag_tap_pkg::ST_CAPTURE_DR: n = tms ? jtag_tap_pkg::ST_EXIT1_DR : jtag_tap_pkg::ST_SHIFT_DR;
         jtag_tap_pkg::ST_SHIFT_DR: n = tms ? jtag_tap_pkg::ST_EXIT1_DR : jtag_tap_pkg::ST_SHIFT_DR;
         jtag_tap_pkg::ST_EXIT1_DR: n = tms ? jtag_tap_pkg::ST_UPDATE_DR : jtag_tap_pkg::ST_PAUSE_DR;
         jtag_tap_pkg::ST_PAUSE_DR: n = tms ? jtag_tap_pkg::ST_EXIT2_DR : jtag_tap_pkg::ST_PAUSE_DR;
         jtag_tap_pkg::ST_EXIT2_DR: n = tms ? jtag_tap_pkg::ST_UPDATE_DR : jtag_tap_pkg::ST_SHIFT_DR;
         jtag_tap_pkg::ST_UPDATE_DR: n = tms ? jtag_tap_pkg::ST_SEL_DR : jtag_tap_pkg::ST_IDLE;
         jtag_tap_pkg::ST_SEL_IR: n = tms ? jtag_tap_pkg::ST_RESET : jtag_tap_pkg::ST_CAPTURE_IR;
         jtag_tap_pkg::ST_CAPTURE_IR: n = tms ? jtag_tap_pkg::ST_EXIT1_IR : jtag_tap_pkg::ST_SHIFT_IR;
         jtag_tap_pkg::ST_SHIFT_IR: n = tms ? jtag_tap_pkg::ST_EXIT1_IR : jtag_tap_pkg::ST_SHIFT_IR;
         jtag_tap_pkg::ST_EXIT1_IR: n = tms ? jtag_tap_pkg::ST_UPDATE_IR : jtag_tap_pkg::ST_PAUSE_IR;
         jtag_tap_pkg::ST_PAUSE_IR: n = tms ? jtag_tap_pkg::ST_EXIT2_IR : jtag_tap_pkg::ST_PAUSE_IR;
         jtag_tap_pkg::ST_EXIT2_IR: n = tms ? jtag_tap_pkg::ST_UPDATE_IR : jtag_tap_pkg::ST_SHIFT_IR;
         jtag_tap_pkg::ST_UPDATE_IR: n = tms ? jtag_tap_pkg::ST_SEL_DR : jtag_tap_pkg::ST_IDLE;
      endcase
      return n;
   endfunction : next_state

   // response fifo between debug engine and update-dr reload
   logic fifo_valid, fifo_pop;
   logic [`TAP_DBG_W-1:0] fifo_data;

   tap_fifo #(
      .WIDTH(`TAP_DBG_W),
      .DEPTH(`TAP_FIFO_DEPTH)
   ) u_rsp_fifo (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(rsp_valid_i),
      .in_ready_o(rsp_ready_o),
      .in_data_i(rsp_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data)
   );

   // controller state
   jtag_tap_pkg::tap_state_e state_q, state_d;
   jtag_tap_pkg::dr_path_e path_q, path_d;
   logic [`TAP_IR_W-1:0] ir_sh_q, ir_sh_d, instr_q, instr_d;
   logic [`TAP_DBG_W-1:0] dr_sh_q, dr_sh_d, dbg_par_q, dbg_par_d;
   logic [`TAP_PROG_W-1:0] prog_par_q, prog_par_d;
   logic tdo_q, tdo_d, oe_q, oe_d, cmd_q, cmd_d, pins_q, pins_d;
   logic in_shift;
   assign in_shift = state_q == jtag_tap_pkg::ST_SHIFT_IR || state_q == jtag_tap_pkg::ST_SHIFT_DR;
   // state, shift and instruction updates wait for a tck edge, except the bypass load in test-logic-reset and the move to reset with bypass on disable
   always_comb begin
      state_d = state_q;
      path_d = path_q;
      ir_sh_d = ir_sh_q;
      instr_d = instr_q;
      dr_sh_d = dr_sh_q;
      dbg_par_d = dbg_par_q;
      prog_par_d = prog_par_q;
      tdo_d = tdo_q;
      oe_d = oe_q;
      cmd_d = 1'h0;
      fifo_pop = 1'h0;
      pins_d = tap_en_i;
      if (!tap_en_i) begin
         state_d = jtag_tap_pkg::ST_RESET;
         instr_d = `TAP_IR_BYPASS;
         path_d = jtag_tap_pkg::PATH_BYPASS;
         oe_d = 1'h0;
      end else begin
         if (state_q == jtag_tap_pkg::ST_RESET) begin
            instr_d = `TAP_IR_BYPASS;
            path_d = jtag_tap_pkg::PATH_BYPASS;
         end
         if (tck_rise) begin
            state_d = next_state(state_q, tms_s2_q);
            if (state_q == jtag_tap_pkg::ST_CAPTURE_IR) begin
               ir_sh_d = `TAP_IR_CAPTURE;
            end
            if (state_q == jtag_tap_pkg::ST_SHIFT_IR) begin
               ir_sh_d = {tdi_s2_q, ir_sh_q[`TAP_IR_W-1:1]};
            end
            if (state_q == jtag_tap_pkg::ST_CAPTURE_DR && path_q == jtag_tap_pkg::PATH_BYPASS) begin
               dr_sh_d = '0;
            end
            if (state_q == jtag_tap_pkg::ST_SHIFT_DR) begin
               unique case (path_q)
                  jtag_tap_pkg::PATH_DEBUG: dr_sh_d = {tdi_s2_q, dr_sh_q[`TAP_DBG_W-1:1]};
                  jtag_tap_pkg::PATH_PROG: begin
                     dr_sh_d = {7'h00, tdi_s2_q, dr_sh_q[`TAP_PROG_W-1:1]};
                  end
                  default: dr_sh_d = {9'h000, tdi_s2_q};
               endcase
            end
         end
         if (tck_fall) begin
            oe_d = in_shift;
            if (state_q == jtag_tap_pkg::ST_SHIFT_IR) begin
               tdo_d = ir_sh_q[0];
            end
            if (state_q == jtag_tap_pkg::ST_SHIFT_DR) begin
               tdo_d = dr_sh_q[0];
            end
            if (state_q == jtag_tap_pkg::ST_UPDATE_IR) begin
               instr_d = ir_sh_q;
               if (ir_sh_q == `TAP_IR_DEBUG) begin
                  path_d = jtag_tap_pkg::PATH_DEBUG;
               end else if (ir_sh_q == `TAP_IR_PROG) begin
                  path_d = jtag_tap_pkg::PATH_PROG;
               end else if (ir_sh_q[0]) begin
                  path_d = ir_sh_q == `TAP_IR_SAMPLE ? path_q : jtag_tap_pkg::PATH_BYPASS;
               end
            end
            if (state_q == jtag_tap_pkg::ST_UPDATE_DR) begin
               if (path_q == jtag_tap_pkg::PATH_DEBUG) begin
                  dbg_par_d = dr_sh_q;
                  cmd_d = 1'h1;
                  fifo_pop = fifo_valid;
                  dr_sh_d = fifo_valid ? fifo_data : dr_sh_q;
               end else if (path_q == jtag_tap_pkg::PATH_PROG) begin
                  prog_par_d = dr_sh_q[`TAP_PROG_W-1:0];
                  dr_sh_d = {7'h00, dr_sh_q[`TAP_PROG_W-1:0]};
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_q <= jtag_tap_pkg::ST_RESET;
         path_q <= jtag_tap_pkg::PATH_BYPASS;
         ir_sh_q <= `TAP_IR_CAPTURE;
         instr_q <= `TAP_IR_BYPASS;
         dr_sh_q <= '0;
         dbg_par_q <= '0;
         prog_par_q <= '0;
         tdo_q <= 1'h0;
         oe_q <= 1'h0;
         cmd_q <= 1'h0;
         pins_q <= `TAP_EN_RESET;
      end else begin
         state_q <= state_d;
         path_q <= path_d;
         ir_sh_q <= ir_sh_d;
         instr_q <= instr_d;
         dr_sh_q <= dr_sh_d;
         dbg_par_q <= dbg_par_d;
         prog_par_q <= prog_par_d;
         tdo_q <= tdo_d;
         oe_q <= oe_d;
         cmd_q <= cmd_d;
         pins_q <= pins_d;
      end
   end

   assign pins_tap_o = pins_q;
   assign tdo_o = tdo_q;
   assign tdo_oe_o = oe_q;
   assign tap_state_o = state_q;
   assign instruction_latch_o = instr_q;
   assign dr_path_o = path_q;
   assign dbg_cmd_valid_o = cmd_q;
   assign dbg_cmd_o = dbg_par_q;
   assign prog_data_o = prog_par_q;

   // high tms rise counter for checking
   logic [2:0] tms_hi_q;
   always_ff @(posedge clk_i) begin
      if (!nrst_i || !tap_en_i) begin
         tms_hi_q <= 3'h0;
      end else if (tck_rise) begin
         tms_hi_q <= !tms_s2_q ? 3'h0 : (tms_hi_q == `TAP_RESET_TMS_EDGES ? tms_hi_q : tms_hi_q + 3'h1);
      end
   end

   a_tdo_fall_only: assert property (@(posedge clk_i) disable iff (!nrst_i)
      $changed(tdo_o) |-> $past(tck_fall) && $past(in_shift))
      else $error("tdo moved off a falling tck");
   a_oe_in_shift: assert property (@(posedge clk_i) disable iff (!nrst_i)
      $rose(tdo_oe_o) |-> $past(in_shift) && $past(tck_fall))
      else $error("tdo enabled outside shift");
   a_stopped_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
      tap_en_i && !tck_rise && !tck_fall && state_q != jtag_tap_pkg::ST_RESET
      |=> $stable(state_q) && $stable(ir_sh_q) && $stable(dr_sh_q) && $stable(instr_q))
      else $error("state moved without a tck edge");
   a_five_high_reset: assert property (@(posedge clk_i) disable iff (!nrst_i)
      tap_en_i && tms_hi_q == `TAP_RESET_TMS_EDGES |-> state_q == jtag_tap_pkg::ST_RESET)
      else $error("five high tms did not reach reset");
   a_reset_bypass: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state_q == jtag_tap_pkg::ST_RESET |=> instr_q == `TAP_IR_BYPASS
      && path_q == jtag_tap_pkg::PATH_BYPASS)
      else $error("reset state without bypass");
   a_capture_ir_value: assert property (@(posedge clk_i) disable iff (!nrst_i)
      tap_en_i && tck_rise && state_q == jtag_tap_pkg::ST_CAPTURE_IR |=> ir_sh_q == 3'h1)
      else $error("capture-ir pattern wrong");
   a_update_ir_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
      tap_en_i && tck_fall && state_q == jtag_tap_pkg::ST_UPDATE_IR
      |=> instr_q == $past(ir_sh_q))
      else $error("instruction latch not loaded");
   a_nop_keeps_path: assert property (@(posedge clk_i) disable iff (!nrst_i)
      tap_en_i && tck_fall && state_q == jtag_tap_pkg::ST_UPDATE_IR && ir_sh_q[2:1] == 2'h0
      |=> $stable(path_q))
      else $error("no-op changed the data path");
   a_bypass_one_bit: assert property (@(posedge clk_i) disable iff (!nrst_i)
      tap_en_i && tck_rise && state_q == jtag_tap_pkg::ST_SHIFT_DR
      && path_q == jtag_tap_pkg::PATH_BYPASS |=> dr_sh_q == {9'h000, $past(tdi_s2_q)})
      else $error("bypass is not one bit");
endmodule : jtag_tap_controller

// ===== test/jtag_host_model.sv
// host side of the test link: drives tck, tms and tdi, samples tdo
`timescale 1ns/1ns

module jtag_host_model (
   // link pins driven by the host
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   // serial answer from the port
   input wire logic tdo_i
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end

   // one 160 ns tck period, eight system clocks; tck rests low between calls
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      tms_o <= tms;
      tdi_o <= tdi;
      #80 tck_o <= 1'b1;
      // tdo settled since the last falling edge
      #40 tdo = tdo_i;
      #40 tck_o <= 1'b0;
   endtask : step
endmodule : jtag_host_model

// ===== test/testbench.sv
// self-checking bench for the test access port controller
`timescale 1ns/1ns
`include "jtag_tap_regs.svh"

module testbench;
   `define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin err_count++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); end end
   localparam int LIMIT = 40000;
   // next state per state code: {tms high nibble, tms low nibble}
   localparam logic [127:0] NXT = 128'hfc9a7c7c8b9adbda46127cfe03125352;
   localparam logic [23:0] CODES = {3'h7, 3'h5, 3'h3, 3'h2, 3'h6, 3'h1, 3'h0, 3'h4};
   logic clk_i, nrst_i, tap_en_i, tck, tms, tdi, tdo_o, tdo_oe_o, pins_tap_o;
   jtag_tap_pkg::tap_state_e tap_state_o;
   logic [`TAP_IR_W-1:0] instruction_latch_o;
   jtag_tap_pkg::dr_path_e dr_path_o, exp_path;
   logic dbg_cmd_valid_o, rsp_valid_i, rsp_ready_o;
   logic [`TAP_DBG_W-1:0] dbg_cmd_o, rsp_data_i, o;
   logic [`TAP_PROG_W-1:0] prog_data_o;
   logic [`TAP_DBG_W-1:0] w [8];
   logic [`TAP_DBG_W-1:0] x [10];
   logic [31:0] rnd_q;
   logic [3:0] exp_st;
   int err_count, compares, cycles, i, pulses;

   jtag_tap_controller jtag_tap_controller_inst (.clk_i(clk_i), .nrst_i(nrst_i),
      .tap_en_i(tap_en_i), .pins_tap_o(pins_tap_o), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .tap_state_o(tap_state_o),
      .instruction_latch_o(instruction_latch_o), .dr_path_o(dr_path_o),
      .dbg_cmd_valid_o(dbg_cmd_valid_o), .dbg_cmd_o(dbg_cmd_o), .rsp_valid_i(rsp_valid_i),
      .rsp_ready_o(rsp_ready_o), .rsp_data_i(rsp_data_i), .prog_data_o(prog_data_o));
   // tdo pulled high while the port does not drive it
   jtag_host_model jtag_host_model_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
      .tdo_i(tdo_oe_o ? tdo_o : 1'b1));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (dbg_cmd_valid_o === 1'b1) pulses++;
      if (cycles == LIMIT) begin
         err_count++;
         final_report();
      end
   end

   task automatic final_report();
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   function automatic logic [31:0] rnd();
      rnd_q = {rnd_q[30:0], rnd_q[31] ^ rnd_q[21] ^ rnd_q[1] ^ rnd_q[0]};
      return rnd_q;
   endfunction : rnd

   function automatic jtag_tap_pkg::dr_path_e path_of(logic [2:0] c, jtag_tap_pkg::dr_path_e p);
      case (c)
         3'h2: return jtag_tap_pkg::PATH_DEBUG;
         3'h4: return jtag_tap_pkg::PATH_PROG;
         3'h3, 3'h5, 3'h7: return jtag_tap_pkg::PATH_BYPASS;
         default: return p;
      endcase
   endfunction : path_of

   task automatic walk(input logic t);
      logic b;
      jtag_host_model_inst.step(t, 1'(rnd()), b);
      exp_st = NXT[{exp_st, t, 2'h0} +: 4];
      #60;
      `CHECK("tap_state_o", exp_st, tap_state_o)
   endtask : walk

   // from idle through one scan and back to idle
   task automatic scan(input logic ir, input int n, input logic [9:0] din, output logic [9:0] q);
      logic b;
      int k;
      q = '0;
      jtag_host_model_inst.step(1'b1, 1'(rnd()), b);
      if (ir) jtag_host_model_inst.step(1'b1, 1'(rnd()), b);
      jtag_host_model_inst.step(1'b0, 1'(rnd()), b);
      jtag_host_model_inst.step(1'b0, 1'(rnd()), b);
      for (k = 0; k < n; k++) begin
         jtag_host_model_inst.step(k == n - 1, din[k], b);
         q[k] = b;
         `CHECK("tdo_oe_o shift", 1'b1, tdo_oe_o)
      end
      jtag_host_model_inst.step(1'b1, 1'(rnd()), b);
      jtag_host_model_inst.step(1'b0, 1'(rnd()), b);
      #60;
      `CHECK("tdo_oe_o idle", 1'b0, tdo_oe_o)
   endtask : scan

   task automatic load_ir(input logic [2:0] c);
      logic [9:0] q;
      scan(1'b1, 3, {7'h0, c}, q);
      `CHECK("ir capture", 3'h1, q[2:0])
      `CHECK("instruction_latch_o", c, instruction_latch_o)
      exp_path = path_of(c, exp_path);
      `CHECK("dr_path_o", exp_path, dr_path_o)
   endtask : load_ir

   initial begin
      rnd_q = 32'h40b3;
      nrst_i = 1'b0;
      tap_en_i = 1'b1;
      rsp_valid_i = 1'b0;
      rsp_data_i = '0;
      exp_st = 4'hf;
      exp_path = jtag_tap_pkg::PATH_BYPASS;
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      #1;
      `CHECK("tap_state_o", jtag_tap_pkg::ST_RESET, tap_state_o)
      `CHECK("instruction_latch_o", `TAP_IR_BYPASS, instruction_latch_o)
      `CHECK("pins_tap_o", 1'b1, pins_tap_o)
      `CHECK("tdo_oe_o", 1'b0, tdo_oe_o)
      repeat (4) @(posedge clk_i);
      for (i = 0; i < 7; i++) walk(i != 3);
      `CHECK("tap_state_o", jtag_tap_pkg::ST_RESET, tap_state_o)
      for (i = 0; i < 120; i++) walk(1'(rnd()));
      for (i = 0; i < 5; i++) walk(1'b1);
      `CHECK("tap_state_o", jtag_tap_pkg::ST_RESET, tap_state_o)
      `CHECK("instruction_latch_o", `TAP_IR_BYPASS, instruction_latch_o)
      `CHECK("dr_path_o", jtag_tap_pkg::PATH_BYPASS, dr_path_o)
      walk(1'b0);
      for (i = 0; i < 8; i++) load_ir(CODES[i*3 +: 3]);
      load_ir(`TAP_IR_PROG);
      x[0] = 10'(rnd());
      x[1] = 10'(rnd());
      scan(1'b0, 3, x[0], o);
      `CHECK("prog_data_o", x[0][2:0], prog_data_o)
      load_ir(`TAP_IR_EXTEST);
      load_ir(`TAP_IR_SAMPLE);
      scan(1'b0, 3, x[1], o);
      `CHECK("prog reload", x[0][2:0], o[2:0])
      load_ir(`TAP_IR_BYPASS);
      scan(1'b0, 4, x[1], o);
      `CHECK("bypass out", {x[1][2:0], 1'b0}, o[3:0])
      // tck parked low for a long stretch
      #4000;
      `CHECK("tap_state_o", jtag_tap_pkg::ST_IDLE, tap_state_o)
      `CHECK("instruction_latch_o", `TAP_IR_BYPASS, instruction_latch_o)
      load_ir(`TAP_IR_DEBUG);
      for (i = 0; i < 8; i++) begin
         w[i] = 10'(rnd());
         @(posedge clk_i);
         rsp_valid_i <= 1'b1;
         rsp_data_i <= w[i];
      end
      @(posedge clk_i);
      rsp_data_i <= 10'h3ff;
      repeat (3) @(posedge clk_i);
      #1;
      `CHECK("rsp_ready_o full", 1'b0, rsp_ready_o)
      @(posedge clk_i);
      rsp_valid_i <= 1'b0;
      pulses = 0;
      for (i = 0; i < 10; i++) begin
         x[i] = 10'(rnd());
         scan(1'b0, 10, x[i], o);
         `CHECK("dbg_cmd_o", x[i], dbg_cmd_o)
         if (i > 0) `CHECK("debug out", (i < 9) ? w[i-1] : x[8], o)
      end
      `CHECK("dbg_cmd_valid_o pulses", 10, pulses)
      `CHECK("rsp_ready_o empty", 1'b1, rsp_ready_o)
      @(posedge clk_i);
      tap_en_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      `CHECK("pins_tap_o", 1'b0, pins_tap_o)
      jtag_host_model_inst.step(1'b0, 1'b0, o[0]);
      #60;
      `CHECK("tap_state_o", jtag_tap_pkg::ST_RESET, tap_state_o)
      @(posedge clk_i);
      tap_en_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      `CHECK("pins_tap_o back", 1'b1, pins_tap_o)
      exp_st = 4'hf;
      exp_path = jtag_tap_pkg::PATH_BYPASS;
      walk(1'b0);
      load_ir(`TAP_IR_DEBUG);
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      #1;
      `CHECK("instruction_latch_o", `TAP_IR_BYPASS, instruction_latch_o)
      `CHECK("dr_path_o", jtag_tap_pkg::PATH_BYPASS, dr_path_o)
      final_report();
   end
endmodule : testbench
